/* File: soec_config.sv */
// soec_config: serially loaded output-pair enable logic with bank output gating
// assumes: config pins and bank clocks are asynchronous to clk_in and sampled here
// assumes: strobe stays high and low for at least three clk_in cycles each
//
// Behaviour
// R1: eleven-stage shift register fed from serial input on strobe edges.
// R2: eleven shifts, then one more strobe copies shift register into control register.
// R3: program-select high: strobe shifts serial bit into stage zero, others move on.
// R4: bit zero is bank b pair four; bit nine bank a pair zero; bit ten, the first bit shifted, unused.
// R5: last bit shifted before commit is least significant bit of the word.
// R6: strobe with program-select low resets state machine, shift and control registers.
// R7: only one commit per reset; later loads ignored until next reset.
// R8: controller resets with a low program-select strobe before reloading.
// R9: program-select low: standard mode, all ten pairs enabled.
// R10: program-select high: committed bits decide which pairs are enabled.
// R11: serial input also selects the clock input source.
// R12: committed one enables a pair, zero powers it off; enabled pair follows bank.
`timescale 1ns/1ps
`default_nettype none
module soec_config
	import soec_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       program_select_in,
	input  wire logic       serial_data_in,
	input  wire logic       config_shift_strobe_in,
	input  wire logic       bank_a_clock_input_in,
	input  wire logic       bank_b_clock_input_in,
	output logic [4:0]      bank_a_output_pairs_out,
	output logic [4:0]      bank_b_output_pairs_out,
	output logic [4:0]      bank_a_output_pairs_n_out,
	output logic [4:0]      bank_b_output_pairs_n_out,
	output logic [4:0]      bank_a_pair_power_out,
	output logic [4:0]      bank_b_pair_power_out,
	output logic            clock_source_select_out,
	output logic [10:0]     output_pair_enable_word_out
);

	// two-stage synchronisers; stage one read only by stage two
	soec_pins_t  pins_s1_q;
	soec_pins_t  pins_s1_d;
	soec_pins_t  pins_s2_q;
	soec_pins_t  pins_s2_d;
	logic [1:0]  bank_s1_q;
	logic [1:0]  bank_s1_d;
	logic [1:0]  bank_s2_q;
	logic [1:0]  bank_s2_d;
	logic        strobe_prev_q;
	logic        strobe_prev_d;

	// strobe edges are found only after both flops, so a metastable stage one never leaks
	always_comb begin
		pins_s1_d.program_select = program_select_in;
		pins_s1_d.serial_data    = serial_data_in;
		pins_s1_d.strobe         = config_shift_strobe_in;
		pins_s2_d                = pins_s1_q;
		bank_s1_d                = {bank_a_clock_input_in, bank_b_clock_input_in};
		bank_s2_d                = bank_s1_q;
		strobe_prev_d            = pins_s2_q.strobe;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pins_s1_q     <= '0;
			pins_s2_q     <= '0;
			bank_s1_q     <= 2'h0;
			bank_s2_q     <= 2'h0;
			strobe_prev_q <= 1'b0;
		end else begin
			pins_s1_q     <= pins_s1_d;
			pins_s2_q     <= pins_s2_d;
			bank_s1_q     <= bank_s1_d;
			bank_s2_q     <= bank_s2_d;
			strobe_prev_q <= strobe_prev_d;
		end
	end

	logic strobe_rise;
	assign strobe_rise = pins_s2_q.strobe & ~strobe_prev_q;

	// configuration state
	soec_state_t state_q;
	soec_state_t state_d;
	logic [10:0] shift_q;
	logic [10:0] shift_d;
	logic [10:0] enable_word_q;
	logic [10:0] enable_word_d;
	logic [3:0]  count_q;
	logic [3:0]  count_d;

	// strobe decode: standard-mode strobe clears; programmed strobes shift, then commit once
	logic clear_now;
	logic shift_now;
	logic commit_now;

	always_comb begin
		clear_now  = 1'b0;
		shift_now  = 1'b0;
		commit_now = 1'b0;
		if (strobe_rise) begin
			if (!pins_s2_q.program_select) begin
				clear_now = 1'b1; // R6
			end else if (state_q == SOEC_SHIFTING) begin
				if (count_q == COUNT_FULL) begin
					commit_now = 1'b1; // R2
				end else begin
					shift_now = 1'b1; // R1 R3
				end
			end
		end
	end

	always_comb begin
		state_d       = state_q;
		shift_d       = shift_q;
		enable_word_d = enable_word_q;
		count_d       = count_q;
		if (clear_now) begin
			state_d       = SOEC_SHIFTING; // R6
			shift_d       = SHIFT_RESET; // R6
			enable_word_d = ENABLE_WORD_RESET; // R6
			count_d       = COUNT_RESET;
		end else if (strobe_rise) begin
			case (state_q)
				SOEC_SHIFTING: begin
					if (commit_now) begin
						// twelfth strobe copies the word; the shift register keeps its bits
						enable_word_d = shift_q; // R2
						state_d       = SOEC_COMMITTED;
					end else if (shift_now) begin
						// new bit enters stage zero; last bit in ends as bit 0
						shift_d = {shift_q[9:0], pins_s2_q.serial_data}; // R1 R3 R4 R5
						count_d = count_q + 4'h1;
					end
				end
				SOEC_COMMITTED: begin
					state_d = SOEC_LOCKED; // R7
				end
				SOEC_LOCKED: begin
					// further programmed strobes are ignored until a standard-mode strobe
					state_d = SOEC_LOCKED; // R7
				end
				default: begin
					state_d = SOEC_SHIFTING;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q       <= SOEC_SHIFTING;
			shift_q       <= SHIFT_RESET;
			enable_word_q <= ENABLE_WORD_RESET;
			count_q       <= COUNT_RESET;
		end else begin
			state_q       <= state_d;
			shift_q       <= shift_d;
			enable_word_q <= enable_word_d;
			count_q       <= count_d;
		end
	end

	// output gating; standard mode forces every pair on
	soec_pair_enables_t en;
	logic [4:0]         a_src;
	logic [4:0]         b_src;
	logic [4:0]         a_true_d;
	logic [4:0]         b_true_d;
	logic [4:0]         a_comp_d;
	logic [4:0]         b_comp_d;
	logic [4:0]         a_power_d;
	logic [4:0]         b_power_d;
	logic               source_sel_d;
	logic [10:0]        word_out_d;

	always_comb begin
		a_src = {PAIRS_PER_BANK{bank_s2_q[1]}};
		b_src = {PAIRS_PER_BANK{bank_s2_q[0]}};
		if (!pins_s2_q.program_select) begin
			en = '{5'h1F, 5'h1F}; // R9
		end else begin
			// word bit zero is bank b pair four, bit nine is bank a pair zero
			for (int k = 0; k < PAIRS_PER_BANK; k++) begin
				en.bank_a[k] = enable_word_q[BANK_A_LSB + PAIRS_PER_BANK - 1 - k]; // R10 R4
				en.bank_b[k] = enable_word_q[BANK_B_LSB + PAIRS_PER_BANK - 1 - k]; // R10 R4
			end
		end
		// disabled pairs drive both legs low, so the load sees no swing
		a_true_d     = en.bank_a & a_src; // R12
		b_true_d     = en.bank_b & b_src; // R12
		a_comp_d     = en.bank_a & ~a_src; // R12
		b_comp_d     = en.bank_b & ~b_src; // R12
		a_power_d    = en.bank_a; // R12
		b_power_d    = en.bank_b; // R12
		// the serial pin doubles as source select, so it follows the pin in every mode
		source_sel_d = pins_s2_q.serial_data; // R11
		word_out_d   = enable_word_q;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			bank_a_output_pairs_out     <= 5'h00;
			bank_b_output_pairs_out     <= 5'h00;
			bank_a_output_pairs_n_out   <= 5'h00;
			bank_b_output_pairs_n_out   <= 5'h00;
			bank_a_pair_power_out       <= 5'h00;
			bank_b_pair_power_out       <= 5'h00;
			clock_source_select_out     <= 1'b0;
			output_pair_enable_word_out <= 11'h000;
		end else begin
			bank_a_output_pairs_out     <= a_true_d;
			bank_b_output_pairs_out     <= b_true_d;
			bank_a_output_pairs_n_out   <= a_comp_d;
			bank_b_output_pairs_n_out   <= b_comp_d;
			bank_a_pair_power_out       <= a_power_d;
			bank_b_pair_power_out       <= b_power_d;
			clock_source_select_out     <= source_sel_d;
			output_pair_enable_word_out <= word_out_d;
		end
	end

endmodule
`default_nettype wire

/* File: soec_pkg.sv */
// soec_pkg: constants and types for the serial output-enable configuration block
// assumes: included before the design module, no other dependencies
package soec_pkg;
	localparam int unsigned SHIFT_LEN            = 11;
	localparam int unsigned PAIRS_PER_BANK       = 5;
	localparam logic [10:0] SHIFT_RESET          = 11'h000;
	localparam logic [10:0] ENABLE_WORD_RESET    = 11'h000;
	localparam logic [3:0]  COUNT_RESET          = 4'h0;
	localparam logic [3:0]  COUNT_FULL           = 4'hB;
	localparam int unsigned BANK_B_LSB           = 0;
	localparam int unsigned BANK_A_LSB           = 5;

	typedef enum logic [2:0] {
		SOEC_SHIFTING  = 3'h1,
		SOEC_COMMITTED = 3'h2,
		SOEC_LOCKED    = 3'h4
	} soec_state_t;

	typedef struct packed {
		logic program_select;
		logic serial_data;
		logic strobe;
	} soec_pins_t;

	typedef struct packed {
		logic [4:0] bank_a;
		logic [4:0] bank_b;
	} soec_pair_enables_t;
endpackage

/* File: soec_config_properties.sv */
// soec_config_properties: port checks of the config block
// assumes: bound onto soec_config, one clock domain
`timescale 1ns/1ps
`default_nettype none
module soec_config_properties (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        program_select_in,
	input wire logic        serial_data_in,
	input wire logic        config_shift_strobe_in,
	input wire logic        bank_a_clock_input_in,
	input wire logic [4:0]  bank_a_output_pairs_out,
	input wire logic [4:0]  bank_a_output_pairs_n_out,
	input wire logic [4:0]  bank_a_pair_power_out,
	input wire logic        bank_b_clock_input_in,
	input wire logic [4:0]  bank_b_output_pairs_out,
	input wire logic [4:0]  bank_b_output_pairs_n_out,
	input wire logic [4:0]  bank_b_pair_power_out,
	input wire logic        clock_source_select_out,
	input wire logic [10:0] output_pair_enable_word_out
);
	wire logic [4:0]  pa = bank_a_pair_power_out;
	wire logic [4:0]  pb = bank_b_pair_power_out;
	wire logic [10:0] wd = output_pair_enable_word_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_std_all_on: assert property ((!program_select_in)[*5] |->
		{pa, pb} == 10'h3FF) else $error("pairs off");
	a_prog_gates_pairs: assert property ((program_select_in && $stable(wd))[*5] |->
		{pa, pb} == {wd[5], wd[6], wd[7], wd[8], wd[9], wd[0], wd[1], wd[2], wd[3], wd[4]})
		else $error("gating");
	a_leg_pairing: assert property ($stable({pa, pb})[*3] |->
		{bank_a_output_pairs_out ^ bank_a_output_pairs_n_out,
		bank_b_output_pairs_out ^ bank_b_output_pairs_n_out} == {pa, pb}) else $error("legs");
	a_b_leg_high: assert property ((bank_b_clock_input_in && $stable(pb))[*5] |->
		bank_b_output_pairs_out == pb) else $error("b leg high");
	a_b_leg_low: assert property ((!bank_b_clock_input_in && $stable(pb))[*5] |->
		bank_b_output_pairs_out == 5'h00) else $error("b leg low");
	a_leg_high: assert property ((bank_a_clock_input_in && $stable(pa))[*5] |->
		bank_a_output_pairs_out == pa) else $error("leg high");
	a_leg_low: assert property ((!bank_a_clock_input_in && $stable(pa))[*5] |->
		bank_a_output_pairs_out == 5'h00) else $error("leg low");
	a_src_select: assert property ($stable(serial_data_in)[*4] |->
		clock_source_select_out == serial_data_in) else $error("source");
	a_word_quiet: assert property ((!config_shift_strobe_in)[*7] |->
		$stable(wd)) else $error("word moved");
	a_low_clear: assert property ((!program_select_in)[*4] ##0
		$rose(config_shift_strobe_in) ##1 (!program_select_in)[*6] |-> wd == 11'h000)
		else $error("no clear");
endmodule
`default_nettype wire

/* File: soec_host.sv */
// soec_host: serial configuration controller model
// assumes: pulse aligns itself to the next clock edge
`timescale 1ns/1ps
`default_nettype none
module soec_host (
	input  wire logic clk_in,
	output var logic  program_select_out,
	output var logic  serial_data_out,
	output var logic  strobe_out
);
	initial begin
		program_select_out = 1'b0;
		serial_data_out = 1'b0;
		strobe_out = 1'b0;
	end
	// one 8-clock strobe period, levels set up 3 clocks ahead of the rise
	task automatic pulse(input logic sel, input logic dat);
		@(posedge clk_in);
		#1 program_select_out = sel;
		serial_data_out = dat;
		repeat (3) @(posedge clk_in);
		#1 strobe_out = 1'b1;
		repeat (4) @(posedge clk_in);
		#1 strobe_out = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: serial_output_enable_config_test.sv */
// serial_output_enable_config_test: self-checking bench of soec_config
// assumes: soec_host drives the config pins
`timescale 1ns/1ps
`default_nettype none
module serial_output_enable_config_test import soec_pkg::*; ;
	logic clk_in = 1'b0, rst_in = 1'b1, bank_a_clock_input_in = 1'b0, bank_b_clock_input_in = 1'b0;
	wire logic program_select_in, serial_data_in, config_shift_strobe_in, clock_source_select_out;
	wire logic [4:0] bank_a_output_pairs_out, bank_b_output_pairs_out, bank_a_output_pairs_n_out;
	wire logic [4:0] bank_b_output_pairs_n_out, bank_a_pair_power_out, bank_b_pair_power_out;
	wire logic [10:0] output_pair_enable_word_out;
	int error_cnt = 0, n_tests = 0, exp_w;
	logic b;
	logic [9:0] exp_p;
	always #50 clk_in = ~clk_in;
	soec_host u_host (.clk_in(clk_in), .program_select_out(program_select_in),
		.serial_data_out(serial_data_in), .strobe_out(config_shift_strobe_in));
	soec_config u_dut (.*);
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("tests=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial forever begin
		repeat (8) @(posedge clk_in);
		#1 {bank_a_clock_input_in, bank_b_clock_input_in} = 2'($urandom);
	end
	initial begin
		#1_000_000 error_cnt++;
		end_of_test();
	end
	initial begin
		exp_w = $urandom(32'h3C64);
		repeat (8) @(posedge clk_in);
		#1 rst_in = 1'b0;
		repeat (6) @(posedge clk_in);
		chk({1'b0, bank_a_pair_power_out, bank_b_pair_power_out}, 11'h3FF);
		for (int i = 0; i < 3; i++) begin
			u_host.pulse(1'b0, 1'b1);
			repeat (6) @(posedge clk_in);
			chk(output_pair_enable_word_out, 11'h000);
			chk({1'b0, bank_a_pair_power_out, bank_b_pair_power_out}, 11'h3FF);
			exp_w = 0;
			for (int j = 0; j < 2 * SHIFT_LEN + 1; j++) begin
				b = 1'($urandom);
				u_host.pulse(1'b1, b);
				if (j < SHIFT_LEN) exp_w = ((exp_w << 1) | b) & 'h7FF;
				if (j == SHIFT_LEN) begin
					repeat (6) @(posedge clk_in);
					chk(output_pair_enable_word_out, 11'(exp_w));
					for (int k = 0; k < 5; k++) begin
						exp_p[5 + k] = exp_w[9 - k];
						exp_p[k] = exp_w[4 - k];
					end
					chk({1'b0, bank_a_pair_power_out, bank_b_pair_power_out}, {1'b0, exp_p});
				end
			end
			repeat (6) @(posedge clk_in);
			chk(output_pair_enable_word_out, 11'(exp_w));
			$display("test %0d done", i);
		end
		end_of_test();
	end
endmodule
bind soec_config soec_config_properties u_prop (.*);
`default_nettype wire
